/* core/emb_pkg.sv */
package emb_pkg;
  // ==========================================================
  // register map (byte addresses)
  localparam logic [7:0] ENGINE_CTRL_STATUS_OFS = 8'h00;
  localparam logic [7:0] ENGINE_BUF_WRITE_WINDOW_OFS = 8'h04;
  localparam logic [7:0] HOST_CTRL_STATUS_OFS = 8'h08;
  localparam logic [7:0] ENGINE_CTRL_STATUS_HOST_ALIAS_OFS = 8'h0c;
  localparam logic [7:0] ENGINE_BUF_READ_WINDOW_OFS = 8'h10;
  localparam logic [7:0] HOST_CTRL_STATUS_ENGINE_VIEW_OFS = 8'h14;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h18;
  localparam logic [7:0] IRQ_MASK_OFS = 8'h1c;
  // ==========================================================
  // control/status fields
  localparam int IRQ_EN_BIT = 0;
  localparam int IRQ_STS_BIT = 1;
  localparam int DOORBELL_BIT = 2;
  localparam int READY_BIT = 3;
  localparam int RDPTR_LSB = 8;
  localparam int WRPTR_LSB = 16;
  localparam int DEPTH_LSB = 24;
  // ==========================================================
  // buffer geometry and reset values
  localparam int BUF_AW = 5;
  localparam logic [7:0] BUF_DEPTH = 8'h20;
  localparam logic [7:0] PTR_MASK = 8'h1f;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;
  // irq status bits: host doorbell, engine doorbell, write on full, read on empty
  localparam int EV_HOST_BELL = 0;
  localparam int EV_ENG_BELL = 1;
  localparam int EV_OVERRUN = 2;
  localparam int EV_UNDERRUN = 3;
endpackage

/* core/emb_bell.sv */
`timescale 1ns/1ps
// doorbell: set by a write of one, clears itself next cycle while raising a sticky status
module emb_bell
  import emb_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic ring,
  input wire logic sts_clr,
  output logic bell,
  output logic sts,
  output logic rise
);
  typedef struct packed {
    logic bell;
    logic sts;
  } emb_bell_st_t;
  emb_bell_st_t cur_ff;
  emb_bell_st_t nxt_st;

  always_comb
  begin
    nxt_st = cur_ff;
    nxt_st.bell = ring;
    // set wins over clear so a doorbell ringing during the w1c is kept
    if (sts_clr)
    begin
      nxt_st.sts = 1'b0;
    end
    if (cur_ff.bell)
    begin
      nxt_st.sts = 1'b1;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cur_ff <= '0;
    end
    else
    begin
      cur_ff <= nxt_st;
    end
  end

  assign bell = cur_ff.bell;
  assign sts = cur_ff.sts;
  assign rise = cur_ff.bell;

  chk_bell_self_clear: assert property (@(posedge mclk) disable iff (sys_rst)
    (bell && !ring) |=> (sts && !bell)) else $error("doorbell did not hand off");
endmodule // emb_bell

/* core/emb_mbox.sv */
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/1ps
// Operation
// [RULE1] firmware checks free slots before writing; holds message otherwise
// [RULE2] each written dword goes into the next buffer slot in order
// [RULE3] firmware may load several messages before ringing, if they fit
// [RULE4] firmware rings engine doorbell by read-modify-write writing one
// [RULE5] engine doorbell sets host status, interrupts host, then self-clears
// [RULE6] host status clears only by host writing one to it
// [RULE7] firmware checks host ready after ringing; zero means restart
// [RULE8] host gets read-only view of engine control/status with filled count
// [RULE9] empty buffer on interrupt means some other cause
// [RULE10] overflow seen by host means firmware fault, reset interface
// [RULE11] each read window access returns next dword and advances read pointer
// [RULE12] host rechecks engine ready after draining; zero discards message
// [RULE13] host acknowledges by ringing host doorbell with read-modify-write
// [RULE14] host doorbell sets engine status, interrupts engine, then self-clears
// [RULE15] host interrupt asserted only while host enable is one
// [RULE16] byte fields read pointer, write pointer, depth; filled is wp minus rp
// [RULE17] pointers wrap modulo depth; overflow when filled exceeds depth (here 8-bit pointers wrap at 256; only the slot index wraps at depth)
module emb_mbox
  import emb_pkg::*;
(
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  output logic host_irq,
  output logic engine_irq,
  output logic sys_irq
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [7:0] wr_ptr;
    logic [7:0] rd_ptr;
    logic [31:0] rdata;
    logic eng_irq_en;
    logic host_irq_en;
    logic engine_ready_flag;
    logic host_ready;
    logic [3:0] irq_sts;
    logic [3:0] irq_mask;
    logic host_irq;
    logic engine_irq;
    logic sys_irq;
  } emb_st_t;
  emb_st_t cur_ff;
  emb_st_t nxt_st;
  logic [31:0] buf_mem [0:31];

  logic engine_doorbell;
  logic host_doorbell;
  logic host_irq_status;
  logic engine_irq_status;
  logic eng_rise;
  logic host_rise;
  logic [7:0] engine_buf_filled_count;
  logic buf_full;
  logic buf_empty;
  logic wr_eng_csr;
  logic wr_host_csr;
  logic push;
  logic pop;
  logic [31:0] engine_ctrl_status;
  logic [31:0] host_ctrl_status;
  logic eng_ring;
  logic host_ring;
  logic eng_sts_w1c;
  logic host_sts_w1c;

  // ==========================================================
  // decode
  assign wr_eng_csr = reg_wr && (reg_addr == ENGINE_CTRL_STATUS_OFS);
  assign wr_host_csr = reg_wr && (reg_addr == HOST_CTRL_STATUS_OFS);
  // strobes named once so the doorbells and the checks see the same terms
  assign eng_ring = wr_eng_csr && reg_wdata[DOORBELL_BIT]; // see [RULE4]
  assign host_ring = wr_host_csr && reg_wdata[DOORBELL_BIT]; // see [RULE13]
  assign eng_sts_w1c = wr_eng_csr && reg_wdata[IRQ_STS_BIT];
  assign host_sts_w1c = wr_host_csr && reg_wdata[IRQ_STS_BIT]; // see [RULE6]
  assign engine_buf_filled_count = cur_ff.wr_ptr - cur_ff.rd_ptr; // see [RULE16]
  // a full buffer is depth filled slots; pointers carry three spare bits above the slot index for that
  assign buf_full = engine_buf_filled_count >= BUF_DEPTH; // see [RULE17]
  assign buf_empty = engine_buf_filled_count == 8'h00;
  assign push = reg_wr && (reg_addr == ENGINE_BUF_WRITE_WINDOW_OFS) && !buf_full;
  assign pop = reg_rd && (reg_addr == ENGINE_BUF_READ_WINDOW_OFS) && !buf_empty;

  // ==========================================================
  // doorbells
  emb_bell u_eng_bell (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ring(eng_ring),
    .sts_clr(host_sts_w1c),
    .bell(engine_doorbell),
    .sts(host_irq_status), // see [RULE5]
    .rise(eng_rise)
  );

  emb_bell u_host_bell (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .ring(host_ring),
    .sts_clr(eng_sts_w1c),
    .bell(host_doorbell),
    .sts(engine_irq_status), // see [RULE14]
    .rise(host_rise)
  );

  // pointers shown as full 8-bit byte fields, not masked to slot index range
  always_comb
  begin
    engine_ctrl_status = '0;
    engine_ctrl_status[IRQ_EN_BIT] = cur_ff.eng_irq_en;
    engine_ctrl_status[IRQ_STS_BIT] = engine_irq_status;
    engine_ctrl_status[DOORBELL_BIT] = engine_doorbell;
    engine_ctrl_status[READY_BIT] = cur_ff.engine_ready_flag;
    engine_ctrl_status[RDPTR_LSB +: 8] = cur_ff.rd_ptr;
    engine_ctrl_status[WRPTR_LSB +: 8] = cur_ff.wr_ptr;
    engine_ctrl_status[DEPTH_LSB +: 8] = BUF_DEPTH;
    host_ctrl_status = '0;
    host_ctrl_status[IRQ_EN_BIT] = cur_ff.host_irq_en;
    host_ctrl_status[IRQ_STS_BIT] = host_irq_status;
    host_ctrl_status[DOORBELL_BIT] = host_doorbell;
    host_ctrl_status[READY_BIT] = cur_ff.host_ready;
  end

  // ==========================================================
  // next state
  always_comb
  begin
    nxt_st = cur_ff;
    if (push)
    begin
      nxt_st.wr_ptr = cur_ff.wr_ptr + 8'h01; // see [RULE2]
    end
    if (pop)
    begin
      nxt_st.rd_ptr = cur_ff.rd_ptr + 8'h01; // see [RULE11]
    end
    if (wr_eng_csr)
    begin
      nxt_st.eng_irq_en = reg_wdata[IRQ_EN_BIT];
      nxt_st.engine_ready_flag = reg_wdata[READY_BIT];
    end
    if (wr_host_csr)
    begin
      nxt_st.host_irq_en = reg_wdata[IRQ_EN_BIT];
      nxt_st.host_ready = reg_wdata[READY_BIT];
    end
    if (reg_wr && (reg_addr == IRQ_MASK_OFS))
    begin
      nxt_st.irq_mask = reg_wdata[3:0];
    end
    nxt_st.rdata = 32'h0000_0000;
    if (reg_rd)
    begin
      unique case (reg_addr)
        ENGINE_CTRL_STATUS_OFS: nxt_st.rdata = engine_ctrl_status;
        ENGINE_CTRL_STATUS_HOST_ALIAS_OFS: nxt_st.rdata = engine_ctrl_status; // see [RULE8]
        HOST_CTRL_STATUS_OFS: nxt_st.rdata = host_ctrl_status;
        HOST_CTRL_STATUS_ENGINE_VIEW_OFS: nxt_st.rdata = host_ctrl_status;
        ENGINE_BUF_READ_WINDOW_OFS: nxt_st.rdata = buf_empty ? 32'h0000_0000 :
          buf_mem[cur_ff.rd_ptr[BUF_AW-1:0]];
        IRQ_STATUS_OFS: nxt_st.rdata = {28'h0000000, cur_ff.irq_sts};
        IRQ_MASK_OFS: nxt_st.rdata = {28'h0000000, cur_ff.irq_mask};
        default: nxt_st.rdata = 32'h0000_0000;
      endcase
    end
    // read clears the summary status; a fresh event in the same cycle survives
    if (reg_rd && (reg_addr == IRQ_STATUS_OFS))
    begin
      nxt_st.irq_sts = 4'h0;
    end
    if (host_rise)
    begin
      nxt_st.irq_sts[EV_HOST_BELL] = 1'b1;
    end
    if (eng_rise)
    begin
      nxt_st.irq_sts[EV_ENG_BELL] = 1'b1;
    end
    if (reg_wr && (reg_addr == ENGINE_BUF_WRITE_WINDOW_OFS) && buf_full)
    begin
      nxt_st.irq_sts[EV_OVERRUN] = 1'b1;
    end
    if (reg_rd && (reg_addr == ENGINE_BUF_READ_WINDOW_OFS) && buf_empty)
    begin
      nxt_st.irq_sts[EV_UNDERRUN] = 1'b1;
    end
    nxt_st.host_irq = host_irq_status && cur_ff.host_irq_en; // see [RULE15]
    nxt_st.engine_irq = engine_irq_status && cur_ff.eng_irq_en; // see [RULE14]
    nxt_st.sys_irq = |(nxt_st.irq_sts & cur_ff.irq_mask);
  end

  always_ff @(posedge mclk)
  begin
    if (sys_rst)
    begin
      cur_ff <= '0;
      cur_ff.irq_mask <= IRQ_MASK_RST;
    end
    else
    begin
      cur_ff <= nxt_st;
    end
  end

  // memory kept out of reset; stale slots are never readable past wr_ptr
  always_ff @(posedge mclk)
  begin
    if (push)
    begin
      buf_mem[cur_ff.wr_ptr[BUF_AW-1:0]] <= reg_wdata; // see [RULE2]
    end
  end

  assign reg_rdata = cur_ff.rdata;
  assign host_irq = cur_ff.host_irq;
  assign engine_irq = cur_ff.engine_irq;
  assign sys_irq = cur_ff.sys_irq;

  // ==========================================================
  // checks
  // host direction; a doorbell rung two cycles running stays up, hence the ring term
  chk_bell_host_sts: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE5]
    (engine_doorbell && !eng_ring) |=> (host_irq_status && !engine_doorbell))
    else $error("engine doorbell did not set host status");
  chk_bell_event: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE5]
    engine_doorbell |=> cur_ff.irq_sts[EV_ENG_BELL])
    else $error("engine doorbell event not recorded");
  chk_host_sts_hold: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE6]
    (host_irq_status && !host_sts_w1c) |=> host_irq_status)
    else $error("host status dropped without w1c");
  chk_host_sts_clear: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE6]
    (host_sts_w1c && !engine_doorbell) |=> !host_irq_status)
    else $error("host status survived its w1c");
  chk_host_irq_gate: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE15]
    host_irq == ($past(host_irq_status) && $past(cur_ff.host_irq_en)))
    else $error("host irq does not follow status and enable");

  // engine direction
  chk_host_bell_eng: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE14]
    (host_doorbell && !host_ring) |=> (engine_irq_status && !host_doorbell)
    ##1 (engine_irq == $past(cur_ff.eng_irq_en)))
    else $error("host doorbell did not set engine status");
  chk_host_event: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE14]
    host_doorbell |=> cur_ff.irq_sts[EV_HOST_BELL])
    else $error("host doorbell event not recorded");
  chk_eng_sts_hold: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE14]
    (engine_irq_status && !eng_sts_w1c) |=> engine_irq_status)
    else $error("engine status dropped without w1c");
  chk_eng_irq_gate: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE14]
    engine_irq == ($past(engine_irq_status) && $past(cur_ff.eng_irq_en)))
    else $error("engine irq does not follow status and enable");

  // buffer; a refused access must leave its pointer where it was
  chk_ptr_advance: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE2]
    push |=> cur_ff.wr_ptr == $past(cur_ff.wr_ptr) + 8'h01)
    else $error("write pointer did not advance");
  chk_pop_advance: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE11]
    pop |=> cur_ff.rd_ptr == $past(cur_ff.rd_ptr) + 8'h01)
    else $error("read pointer did not advance");
  chk_overrun_drop: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE17]
    (reg_wr && reg_addr == ENGINE_BUF_WRITE_WINDOW_OFS && buf_full) |=>
    ($stable(cur_ff.wr_ptr) && cur_ff.irq_sts[EV_OVERRUN]))
    else $error("write on full not refused");
  chk_underrun_hold: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE11]
    (reg_rd && reg_addr == ENGINE_BUF_READ_WINDOW_OFS && buf_empty) |=>
    ($stable(cur_ff.rd_ptr) && reg_rdata == 32'h0000_0000 && cur_ff.irq_sts[EV_UNDERRUN]))
    else $error("read on empty not refused");
  chk_fill_bound: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE17]
    engine_buf_filled_count <= BUF_DEPTH)
    else $error("filled count beyond depth");

  // register bus and summary interrupt
  chk_alias_view: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE8]
    (reg_rd && reg_addr == ENGINE_CTRL_STATUS_HOST_ALIAS_OFS) |=>
    reg_rdata[WRPTR_LSB +: 8] == $past(cur_ff.wr_ptr))
    else $error("alias view wrong");
  chk_ctrl_ptr_view: assert property (@(posedge mclk) disable iff (sys_rst) // see [RULE16]
    (reg_rd && reg_addr == ENGINE_CTRL_STATUS_OFS) |=>
    reg_rdata[RDPTR_LSB +: 8] == $past(cur_ff.rd_ptr))
    else $error("read pointer field wrong");
  chk_rdata_idle: assert property (@(posedge mclk) disable iff (sys_rst)
    !reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("read data stood outside its cycle");
  chk_irq_sticky: assert property (@(posedge mclk) disable iff (sys_rst)
    !(reg_rd && reg_addr == IRQ_STATUS_OFS) |=>
    ((cur_ff.irq_sts & $past(cur_ff.irq_sts)) == $past(cur_ff.irq_sts)))
    else $error("status bit lost without a read");
  chk_sys_irq_level: assert property (@(posedge mclk) disable iff (sys_rst)
    sys_irq == |(cur_ff.irq_sts & $past(cur_ff.irq_mask)))
    else $error("summary irq does not follow masked status");

  // main scenarios
  cov_eng_bell: cover property (@(posedge mclk) engine_doorbell ##2 host_irq);
  cov_host_bell: cover property (@(posedge mclk) host_doorbell ##2 engine_irq);
  cov_full: cover property (@(posedge mclk) buf_full);
  cov_overrun: cover property (@(posedge mclk) $rose(cur_ff.irq_sts[EV_OVERRUN]));
  cov_drain: cover property (@(posedge mclk) pop ##1 buf_empty);
endmodule // emb_mbox

/* bench/emb_fw_model.sv */
`timescale 1ns/1ps
// =========================================
// bus master standing in for firmware and host software
module emb_fw_model
  import emb_pkg::*;
(
  input wire logic mclk,
  output logic [7:0] reg_addr,
  output logic [31:0] reg_wdata,
  output logic reg_wr,
  output logic reg_rd,
  input wire logic [31:0] reg_rdata
);
  initial
  begin
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'h0;
    reg_rd = 1'h0;
  end

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge mclk);
    reg_wr <= 1'h0;
    // released data must not look like a held value
    reg_wdata <= ~d;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    @(posedge mclk);
    reg_rd <= 1'h0;
    #1;
    d = reg_rdata;
  endtask

  // doorbells are rung by writing back the read value, so a set w1c status bit is cleared too
  task automatic rmw(input logic [7:0] a, input logic [31:0] m);
    logic [31:0] d;
    rd(a, d);
    wr(a, d | m);
  endtask

  // only writes when the whole batch fits in the free slots
  task automatic send(input int n, input logic [31:0] base);
    logic [31:0] d;
    logic [7:0] filled;
    rd(ENGINE_CTRL_STATUS_OFS, d);
    filled = d[23:16] - d[15:8];
    if (d[31:24] - filled >= 8'(n))
    begin
      for (int i = 0; i < n; i++)
        wr(ENGINE_BUF_WRITE_WINDOW_OFS, base + 32'(i));
    end
  endtask
endmodule // emb_fw_model

/* bench/tb.sv */
`timescale 1ns/1ps
module tb
  import emb_pkg::*;
;
  logic mclk;
  logic sys_rst;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic host_irq;
  logic engine_irq;
  logic sys_irq;
  logic [31:0] d;
  int num_errors = 0;
  int checked = 0;

  emb_mbox dut (.mclk(mclk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .host_irq(host_irq),
    .engine_irq(engine_irq), .sys_irq(sys_irq));
  emb_fw_model fw (.mclk(mclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  // =========================================
  // helpers
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic rchk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] v;
    fw.rd(a, v);
    chk(v, exp);
  endtask

  // bounded wait on an irq output, then compare it
  task automatic wait_irq(input bit eng);
    for (int i = 0; i < 8 && (eng ? engine_irq : host_irq) !== 1'h1; i++)
      @(posedge mclk);
    #1;
    chk({31'h0, eng ? engine_irq : host_irq}, 32'h1);
  endtask

  task automatic summarize();
    if (num_errors == 0 && checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  initial
  begin
    mclk = 1'h0;
    forever #5 mclk = ~mclk;
  end

  initial
  begin
    #200000;
    num_errors++;
    summarize();
  end

  // =========================================
  // main sequence
  initial
  begin
    sys_rst = 1'h1;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'h0;
    fw.wr(HOST_CTRL_STATUS_OFS, 32'h9);
    fw.wr(ENGINE_CTRL_STATUS_OFS, 32'h9);
    fw.wr(IRQ_MASK_OFS, 32'h2);
    rchk(ENGINE_CTRL_STATUS_OFS, 32'h2000_0009);
    fw.send(3, 32'hc0de_0000);
    // alias is read only: the write must change nothing
    fw.wr(ENGINE_CTRL_STATUS_HOST_ALIAS_OFS, 32'hffff_ffff);
    rchk(ENGINE_CTRL_STATUS_HOST_ALIAS_OFS, 32'h2003_0009);
    fw.rmw(ENGINE_CTRL_STATUS_OFS, 32'h4);
    wait_irq(0);
    rchk(HOST_CTRL_STATUS_ENGINE_VIEW_OFS, 32'hb);
    rchk(ENGINE_CTRL_STATUS_OFS, 32'h2003_0009);
    rchk(HOST_CTRL_STATUS_OFS, 32'hb);
    fw.wr(HOST_CTRL_STATUS_OFS, 32'h9);
    repeat (3) @(posedge mclk);
    chk({31'h0, host_irq}, 32'h1);
    fw.wr(HOST_CTRL_STATUS_OFS, 32'hb);
    repeat (3) @(posedge mclk);
    chk({31'h0, host_irq}, 32'h0);
    for (int i = 0; i < 3; i++)
      rchk(ENGINE_BUF_READ_WINDOW_OFS, 32'hc0de_0000 + 32'(i));
    rchk(ENGINE_BUF_READ_WINDOW_OFS, 32'h0);
    rchk(ENGINE_CTRL_STATUS_HOST_ALIAS_OFS, 32'h2003_0309);
    fw.rmw(HOST_CTRL_STATUS_OFS, 32'h4);
    wait_irq(1);
    rchk(HOST_CTRL_STATUS_OFS, 32'h9);
    rchk(ENGINE_CTRL_STATUS_OFS, 32'h2003_030b);
    rchk(IRQ_STATUS_OFS, 32'hb);
    rchk(IRQ_STATUS_OFS, 32'h0);
    // host enable off: status still sets, output stays low
    fw.wr(HOST_CTRL_STATUS_OFS, 32'h8);
    fw.rmw(ENGINE_CTRL_STATUS_OFS, 32'h4);
    repeat (5) @(posedge mclk);
    chk({31'h0, host_irq}, 32'h0);
    chk({31'h0, engine_irq}, 32'h0);
    rchk(HOST_CTRL_STATUS_OFS, 32'ha);
    rchk(ENGINE_CTRL_STATUS_HOST_ALIAS_OFS, 32'h2003_0309);
    // one write past full is dropped and flagged
    for (int i = 0; i < 33; i++)
      fw.wr(ENGINE_BUF_WRITE_WINDOW_OFS, 32'h5a00_0000 + 32'(i));
    rchk(ENGINE_CTRL_STATUS_HOST_ALIAS_OFS, 32'h2023_0309);
    #1;
    chk({31'h0, sys_irq}, 32'h1);
    rchk(IRQ_STATUS_OFS, 32'h6);
    repeat (3) @(posedge mclk);
    chk({31'h0, sys_irq}, 32'h0);
    for (int i = 0; i < 32; i++)
      rchk(ENGINE_BUF_READ_WINDOW_OFS, 32'h5a00_0000 + 32'(i));
    rchk(ENGINE_CTRL_STATUS_HOST_ALIAS_OFS, 32'h2023_2309);
    summarize();
  end
endmodule // tb
